// File: rtl/plm_pkg.sv
// shared constants, register map and carrier types for the pll lock and clock-loss monitor
package plm_pkg;

    // apb register byte offsets
    localparam logic [11:0] ADDR_CTRL  = 12'h000;  // synth_control_reg
    localparam logic [11:0] ADDR_STAT  = 12'h004;  // synth_status_reg
    localparam logic [11:0] ADDR_CAUSE = 12'h008;  // reset_cause_reg

    // synth_control_reg fields
    localparam int CTRL_RFD_LSB   = 0;
    localparam int CTRL_MFD_LSB   = 3;
    localparam int CTRL_LOCK_LOSS_RESET_ENABLE_BIT = 6;
    localparam int CTRL_CLOCK_LOSS_DETECT_ENABLE_BIT = 7;
    localparam int CTRL_CLOCK_LOSS_RESET_ENABLE_BIT = 8;
    localparam int CTRL_CKDIS_BIT = 9;
    localparam logic [2:0] MFD_RESET = 3'h0;
    localparam logic [2:0] RFD_RESET = 3'h1;

    // synth_status_reg fields
    localparam int STAT_LOCK_BIT  = 0;
    localparam int STAT_STICKY_LOCK_FLAG_BIT = 1;
    localparam int STAT_STICKY_CLOCK_LOSS_FLAG_BIT  = 2;
    localparam int STAT_MODE_LSB  = 4;
    localparam int STAT_CP_LSB    = 8;

    // reset_cause_reg fields, write one to clear
    localparam int CAUSE_LOL_BIT = 0;
    localparam int CAUSE_LOC_BIT = 1;

    // charge pump thresholds on the multiply divider
    localparam logic [2:0] CP_2X_MIN = 3'h2;
    localparam logic [2:0] CP_4X_MIN = 3'h6;

    // timing at the 40 mhz bus clock
    localparam int CLK_PERIOD_NS     = 25;
    localparam int LOC_MIN_PERIOD_NS = 2000;
    localparam int LOC_CYC           = (LOC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYC  = 3;

    // lock detector tolerances, relaxed is the tight window widened by half again
    localparam logic [7:0] TOL_TIGHT = 8'h02;
    localparam logic [7:0] TOL_RELAX = 8'h03;

    typedef enum logic [1:0] {MODE_EXT, MODE_ONE, MODE_NRM_EXT, MODE_NRM_XTAL} plm_mode_t;
    typedef enum logic [1:0] {FB_NONE, FB_SYSTEM_CLOCK_PIN, FB_VCO_HALF, FB_VCO_DIV} plm_fbsel_t;
    typedef enum logic [1:0] {CP_FIXED, CP_1X, CP_2X, CP_4X} plm_cp_t;
    typedef enum logic [1:0] {LD_OFF, LD_SHORT, LD_LONG} plm_ld_t;

    typedef struct packed {
        logic       system_clock_pin_dis;
        logic       loc_re;
        logic       loc_en;
        logic       lol_re;
        logic [2:0] feedback_multiply_divider;
        logic [2:0] output_reduce_divider;
    } plm_ctrl_t;

    localparam plm_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, MFD_RESET, RFD_RESET};

    typedef struct packed {
        plm_fbsel_t fb_sel;
        plm_cp_t    cp;
        logic [3:0] mult;
        logic [5:0] vco_ratio;
        logic [2:0] output_reduce_divider;
        logic       src_pll;
    } plm_synth_t;

endpackage

// File: rtl/plm_clk_sampler.sv
// two-flop synchroniser for a pin with edge pulses taken after the second stage
`timescale 1ns/100ps
module plm_clk_sampler (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // meta_r feeds sync_r alone; edges are judged one stage later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o  = sync_r & ~prev_r;
    assign fall_o  = ~sync_r & prev_r;
endmodule

// File: rtl/plm_monitor.sv
// pll lock detector, clock-loss monitor, synthesis control and reset request with apb registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
import plm_pkg::*;

// Operation
// - multiply reference by two to nine
// - reduce divider outside feedback loop
// - feedback source chosen by clock mode
// - charge pump current from multiply divider
// - pulse up on lag, down on lead
// - oscillator at four times system frequency
// - one-to-one mode bypasses multiply divider
// - tight count n, then n plus k
// - mismatch drops lock and restarts tight
// - external mode never sticky_lock_flag
// - first lock sets flags; change clears
// - pll stays clock source while relocking
// - sticky relocks only after divider change or reset
// - stop exit restores previous sticky flag
// - lock loss reset, flags cleared, cause
// - reset held until reference and, in pll modes, lock
// - external mode ignores lock-loss reset
// - clock loss detection sets sticky flag
// - external mode disables clock loss detection
// - clock loss reset clears flag, cause
// - external mode ignores clock-loss reset
// - reset restores startup register values
// - strap bits decode the clock mode
// - sticky clock-loss zero in external mode
module plm_monitor #(
    parameter logic [7:0] LOCK_N = 8'h40,
    parameter logic [7:0] LOCK_K = 8'h20
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [11:0]    paddr,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           ref_clk_pin,
    input  wire logic           fb_system_clock_pin_pin,
    input  wire logic           fb_vco_half_pin,
    input  wire logic           fb_vco_div_pin,
    input  wire logic           pll_enable_strap,
    input  wire logic           pll_choose_strap,
    input  wire logic           pll_reference_strap,
    input  wire logic           stop_pll_off,
    output logic                sys_reset_o,
    output plm_pkg::plm_synth_t synth_cfg_o,
    output logic                pfd_up_o,
    output logic                pfd_down_o
);
    import plm_pkg::*;

    localparam int NPIN = 7;

    function automatic plm_mode_t decode_mode(input logic [2:0] s);
        case (s)
            3'h4:    decode_mode = MODE_ONE;
            3'h6:    decode_mode = MODE_NRM_EXT;
            3'h7:    decode_mode = MODE_NRM_XTAL;
            default: decode_mode = MODE_EXT;
        endcase
    endfunction

    function automatic logic within_tol(input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] tol);
        within_tol = (a >= b) ? ((a - b) <= tol) : ((b - a) <= tol);
    endfunction

    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;
    logic [NPIN-1:0] pin_in;

    assign pin_in = {pll_enable_strap, pll_choose_strap, pll_reference_strap,
                     fb_vco_div_pin, fb_vco_half_pin, fb_system_clock_pin_pin, ref_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_samp
            plm_clk_sampler u_samp (
                .pclk    (pclk),
                .presetn (presetn),
                .pin_i   (pin_in[gi]),
                .level_o (pin_lvl[gi]),
                .rise_o  (pin_rise[gi]),
                .fall_o  (pin_fall[gi])
            );
        end
    endgenerate

    plm_mode_t   mode_r;
    logic        mode_done_r;
    logic [1:0]  settle_r;
    plm_ctrl_t   ctrl_r;
    plm_ld_t     st_r;
    logic        relax_r;
    logic [7:0]  ref_cnt_r;
    logic [7:0]  fb_cnt_r;
    logic        lock_r;
    logic        sticky_r;
    logic        arm_r;
    logic        save_r;
    logic        restore_r;
    logic        stop_q_r;
    logic        clk_loss_r;
    logic [7:0]  ref_wd_r;
    logic [7:0]  fb_wd_r;
    logic        ref_seen_r;
    logic        rst_req_r;
    logic [1:0]  cause_r;
    logic        up_r;
    logic        dn_r;
    logic [31:0] prdata_r;
    plm_synth_t  synth_r;

    logic       pll_mode;
    logic       ext_mode;
    logic       fb_rise;
    logic       fb_fall;
    logic       cmp_ev;
    logic       match;
    logic       wr_ctrl;
    logic       wr_cause;
    logic       mfd_chg;
    logic       lose_ev;
    logic       lock_rise;
    logic       loc_ev;
    logic       int_rst;
    logic       mapped;
    plm_ctrl_t  wr_val;

    // straps settle through the samplers before they are latched once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_r    <= 2'h0;
            mode_done_r <= 1'b0;
            mode_r      <= MODE_EXT;
        end else if (!mode_done_r) begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == 2'(STRAP_SETTLE_CYC)) begin
                mode_done_r <= 1'b1;
                mode_r      <= decode_mode(pin_lvl[6:4]);
            end
        end
    end

    assign ext_mode = (mode_r == MODE_EXT);
    assign pll_mode = mode_done_r && !ext_mode;

    // feedback source per mode
    always_comb begin
        fb_rise = 1'b0;
        fb_fall = 1'b0;
        unique case (synth_r.fb_sel)
            FB_SYSTEM_CLOCK_PIN: begin
                fb_rise = pin_rise[1];
                fb_fall = pin_fall[1];
            end
            FB_VCO_HALF: begin
                fb_rise = pin_rise[2];
                fb_fall = pin_fall[2];
            end
            FB_VCO_DIV: begin
                fb_rise = pin_rise[3];
                fb_fall = pin_fall[3];
            end
            FB_NONE: begin
                fb_rise = 1'b0;
                fb_fall = 1'b0;
            end
        endcase
    end

    assign wr_ctrl  = psel && penable && pwrite && (paddr == ADDR_CTRL);
    assign wr_cause = psel && penable && pwrite && (paddr == ADDR_CAUSE);
    assign wr_val   = plm_ctrl_t'(pwdata[CTRL_CKDIS_BIT:0]);
    assign mfd_chg  = wr_ctrl && (wr_val.feedback_multiply_divider != ctrl_r.feedback_multiply_divider);

    assign cmp_ev = (st_r == LD_SHORT && ref_cnt_r == LOCK_N) ||
                    (st_r == LD_LONG && ref_cnt_r == 8'(LOCK_N + LOCK_K));
    assign match  = within_tol(ref_cnt_r, fb_cnt_r, relax_r ? TOL_RELAX : TOL_TIGHT);
    assign lose_ev   = cmp_ev && !match && lock_r;
    assign lock_rise = cmp_ev && match && (st_r == LD_LONG) && !lock_r;
    assign loc_ev = pll_mode && ctrl_r.loc_en &&
                    (ref_wd_r >= 8'(LOC_CYC) || fb_wd_r >= 8'(LOC_CYC));
    // reset requests are ignored in external mode
    assign int_rst = pll_mode && ((lose_ev && !stop_q_r && ctrl_r.lol_re) ||
                                  (loc_ev && ctrl_r.loc_re));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (int_rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= wr_val;
        end
    end

    // alternating short and long count windows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= LD_OFF;
            relax_r   <= 1'b0;
            ref_cnt_r <= 8'h00;
            fb_cnt_r  <= 8'h00;
        end else if (!pll_mode) begin
            st_r      <= LD_OFF;
            relax_r   <= 1'b0;
            ref_cnt_r <= 8'h00;
            fb_cnt_r  <= 8'h00;
        end else if (st_r == LD_OFF || mfd_chg || int_rst || (cmp_ev && !match)) begin
            st_r      <= LD_SHORT;
            relax_r   <= 1'b0;
            ref_cnt_r <= 8'h00;
            fb_cnt_r  <= 8'h00;
        end else if (cmp_ev) begin
            st_r      <= (st_r == LD_SHORT) ? LD_LONG : LD_SHORT;
            relax_r   <= relax_r | (st_r == LD_LONG);
            ref_cnt_r <= 8'h00;
            fb_cnt_r  <= 8'h00;
        end else begin
            ref_cnt_r <= ref_cnt_r + {7'h00, pin_rise[0]};
            fb_cnt_r  <= (fb_cnt_r == 8'hFF) ? fb_cnt_r : fb_cnt_r + {7'h00, fb_rise};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (!pll_mode || mfd_chg || int_rst || lose_ev) begin
            lock_r <= 1'b0;
        end else if (lock_rise) begin
            lock_r <= 1'b1;
        end
    end

    // arm_r says whether the next lock may set the sticky flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_r  <= 1'b0;
            arm_r     <= 1'b1;
            save_r    <= 1'b0;
            restore_r <= 1'b0;
            stop_q_r  <= 1'b0;
        end else begin
            stop_q_r <= stop_pll_off;
            if (stop_pll_off && !stop_q_r) begin
                save_r    <= sticky_r;
                restore_r <= 1'b1;
            end
            if (!pll_mode || int_rst) begin
                sticky_r  <= 1'b0;
                arm_r     <= 1'b1;
                restore_r <= 1'b0;
            end else if (mfd_chg) begin
                sticky_r <= 1'b0;
                arm_r    <= 1'b1;
            end else if (lose_ev && !stop_q_r && !restore_r) begin
                sticky_r <= 1'b0;
                arm_r    <= 1'b0;
            end else if (lock_rise) begin
                if (restore_r && !stop_q_r) begin
                    sticky_r  <= save_r;
                    restore_r <= 1'b0;
                end else begin
                    sticky_r <= arm_r;
                end
            end
        end
    end

    // clock watchdogs: a clock below the minimum rate lets its count reach the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_wd_r   <= 8'h00;
            fb_wd_r    <= 8'h00;
            ref_seen_r <= 1'b0;
        end else begin
            ref_seen_r <= ref_seen_r | pin_rise[0];
            if (!pll_mode || pin_rise[0] || int_rst) begin
                ref_wd_r <= 8'h00;
            end else if (ref_wd_r != 8'hFF) begin
                ref_wd_r <= ref_wd_r + 8'h01;
            end
            if (!pll_mode || fb_rise || int_rst) begin
                fb_wd_r <= 8'h00;
            end else if (fb_wd_r != 8'hFF) begin
                fb_wd_r <= fb_wd_r + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_loss_r <= 1'b0;
        end else if (!pll_mode || int_rst) begin
            clk_loss_r <= 1'b0;
        end else if (loc_ev) begin
            clk_loss_r <= 1'b1;
        end
    end

    // reset request stays up until the reference runs and, with the pll, lock is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_req_r <= 1'b1;
        end else if (int_rst) begin
            rst_req_r <= 1'b1;
        end else if (mode_done_r && ref_seen_r && (ext_mode || lock_r)) begin
            rst_req_r <= 1'b0;
        end
    end

    // causes survive the requested reset; a new cause beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_cause && pwdata[i]) begin
                    cause_r[i] <= 1'b0;
                end
            end
            if (int_rst && lose_ev && !stop_q_r && ctrl_r.lol_re) begin
                cause_r[CAUSE_LOL_BIT] <= 1'b1;
            end
            if (int_rst && loc_ev && ctrl_r.loc_re) begin
                cause_r[CAUSE_LOC_BIT] <= 1'b1;
            end
        end
    end

    // dual latch detector on falling edges: whichever edge comes first holds its side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else if (!pll_mode || ((up_r | pin_fall[0]) && (dn_r | fb_fall))) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else begin
            up_r <= up_r | pin_fall[0];
            dn_r <= dn_r | fb_fall;
        end
    end

    // synthesis settings; the reduce divider never reaches the feedback path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_r <= '{FB_NONE, CP_FIXED, 4'h0, 6'h00, RFD_RESET, 1'b0};
        end else begin
            synth_r.output_reduce_divider     <= ctrl_r.output_reduce_divider;
            synth_r.src_pll <= pll_mode;
            unique case (mode_r)
                MODE_EXT: begin
                    synth_r.fb_sel    <= FB_NONE;
                    synth_r.cp        <= CP_FIXED;
                    synth_r.mult      <= 4'h1;
                    synth_r.vco_ratio <= 6'h00;
                end
                MODE_ONE: begin
                    synth_r.fb_sel    <= ctrl_r.system_clock_pin_dis ? FB_VCO_HALF : FB_SYSTEM_CLOCK_PIN;
                    synth_r.cp        <= CP_FIXED;
                    synth_r.mult      <= 4'h1;
                    synth_r.vco_ratio <= 6'h04;
                end
                MODE_NRM_EXT, MODE_NRM_XTAL: begin
                    synth_r.fb_sel    <= FB_VCO_DIV;
                    synth_r.cp        <= (ctrl_r.feedback_multiply_divider >= CP_4X_MIN) ? CP_4X :
                                         (ctrl_r.feedback_multiply_divider >= CP_2X_MIN) ? CP_2X : CP_1X;
                    synth_r.mult      <= {1'b0, ctrl_r.feedback_multiply_divider} + 4'h2;
                    synth_r.vco_ratio <= {1'b0, ctrl_r.feedback_multiply_divider, 2'h0} + 6'h08;
                end
            endcase
        end
    end

    // read data is captured in the setup phase so the access phase answers at once
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) || (paddr == ADDR_CAUSE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_r <= 32'h0000_0000;
            if (paddr == ADDR_CTRL) begin
                prdata_r[CTRL_CKDIS_BIT:0] <= ctrl_r;
            end else if (paddr == ADDR_STAT) begin
                prdata_r[STAT_LOCK_BIT]             <= lock_r;
                prdata_r[STAT_STICKY_LOCK_FLAG_BIT]            <= sticky_r;
                prdata_r[STAT_STICKY_CLOCK_LOSS_FLAG_BIT]             <= clk_loss_r;
                prdata_r[STAT_MODE_LSB +: 2]        <= mode_r;
                prdata_r[STAT_CP_LSB +: 2]          <= synth_r.cp;
            end else if (paddr == ADDR_CAUSE) begin
                prdata_r[1:0] <= cause_r;
            end
        end
    end

    assign prdata      = prdata_r;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !mapped;
    assign sys_reset_o = rst_req_r;
    assign synth_cfg_o = synth_r;
    assign pfd_up_o    = up_r;
    assign pfd_down_o  = dn_r;

    sequence s_short_pass;
        cmp_ev && match && st_r == LD_SHORT;
    endsequence

    sequence s_long_pass;
        cmp_ev && match && st_r == LD_LONG;
    endsequence

    AST_EXT_NO_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode |-> !lock_r) else $error("lock shown in external mode");
    AST_EXT_NO_LOC: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode |-> !clk_loss_r) else $error("clock loss shown in external mode");
    AST_LOCK_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
        s_long_pass ##0 (!mfd_chg && !int_rst) |=> relax_r && st_r == LD_SHORT)
        else $error("criterion not relaxed");
    AST_SHORT_TO_LONG: assert property (@(posedge pclk) disable iff (!presetn)
        s_short_pass ##0 (!mfd_chg && !int_rst) |=> st_r == LD_LONG && ref_cnt_r == 8'h00)
        else $error("no long window");
    AST_MISMATCH: assert property (@(posedge pclk) disable iff (!presetn)
        lose_ev |=> !lock_r && !relax_r && st_r == LD_SHORT) else $error("mismatch kept lock");
    AST_MFD_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        mfd_chg |=> !lock_r && !sticky_r) else $error("divider change kept lock flags");
    AST_CP_4X: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_r == MODE_NRM_XTAL && ctrl_r.feedback_multiply_divider >= 3'h6) |=> synth_r.cp == CP_4X)
        else $error("charge pump not 4x");
    AST_LOL_RST: assert property (@(posedge pclk) disable iff (!presetn)
        (lose_ev && ctrl_r.lol_re && !stop_q_r) |=> rst_req_r && cause_r[0] && !sticky_r)
        else $error("lock loss reset missing");
    AST_RST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        rst_req_r && pll_mode && !lock_r |=> rst_req_r) else $error("reset left without lock");
    AST_LOC_SET: assert property (@(posedge pclk) disable iff (!presetn)
        loc_ev && !ctrl_r.loc_re |=> clk_loss_r [*2]) else $error("clock loss not sticky");
endmodule

// File: tb/plm_clk_src.sv
// behavioural reference oscillator and feedback clock source for the monitor bench
`timescale 1ns/100ps
module plm_clk_src (
    input  wire logic run,
    input  wire logic fb_fast,
    output logic      ref_clk,
    output logic      fb_clk
);
    initial begin
        ref_clk = 1'b0;
        forever begin
            #200;
            if (run) ref_clk = ~ref_clk;
        end
    end
    // a fast feedback models a loop that has drifted off frequency
    initial begin
        fb_clk = 1'b0;
        forever begin
            if (fb_fast) #125; else #200;
            if (run) fb_clk = ~fb_clk;
        end
    end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the pll lock and clock-loss monitor
`timescale 1ns/100ps
module tb_top;
    import plm_pkg::*;
    typedef struct packed {logic [32:0] v; logic [32:0] m;} plm_exp_t;
    logic        pclk, presetn, psel, penable, pwrite, want, pready, pslverr;
    logic        run, fb_fast, ref_clk, fb_clk, sys_reset_o, stop_pll_off, pfd_up, pfd_dn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  strap;
    logic [15:0] lfsr;
    plm_synth_t  synth_cfg_o;
    plm_exp_t    exq[$];
    plm_exp_t    e;
    int          err_total, n_compared, i;
    plm_clk_src plm_clk_src_inst (.run(run), .fb_fast(fb_fast), .ref_clk(ref_clk),
        .fb_clk(fb_clk));
    plm_monitor #(.LOCK_N(8'h08), .LOCK_K(8'h04)) plm_monitor_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_clk_pin(ref_clk), .fb_system_clock_pin_pin(fb_clk), .fb_vco_half_pin(fb_clk),
        .fb_vco_div_pin(fb_clk), .pll_enable_strap(strap[2]), .pll_choose_strap(strap[1]),
        .pll_reference_strap(strap[0]), .stop_pll_off(stop_pll_off),
        .sys_reset_o(sys_reset_o), .synth_cfg_o(synth_cfg_o), .pfd_up_o(pfd_up),
        .pfd_down_o(pfd_dn));
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic c);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d; want <= c;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            check("apb ready", 1'b0, 1'b1);
            end_sim();
        end
        q = prdata;
        psel <= 1'b0; penable <= 1'b0; want <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [32:0] m, logic [32:0] v);
        exq.push_back('{v, m});
        apb(a, 1'b0, 32'h0, 1'b1);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(a, 1'b1, d, 1'b0);
    endtask
    // polls one status bit up to 700 reads; a poll that never matches fails and ends the run
    task automatic poll(int b, logic v);
        for (int n = 0; n < 700; n++) begin
            apb(ADDR_STAT, 1'b0, 32'h0, 1'b0);
            if (q[b] === v) return;
        end
        check("status poll", 1'b0, 1'b1);
        end_sim();
    endtask
    task automatic wait_rst(logic v);
        for (int n = 0; n < 3000; n++) begin
            @(posedge pclk);
            if (sys_reset_o === v) return;
        end
        check("reset wait", 1'b0, 1'b1);
        end_sim();
    endtask
    task automatic do_reset(logic [2:0] s);
        strap <= s; presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    function automatic logic [31:0] ctl(logic [2:0] mf, logic [2:0] rf, logic [3:0] f);
        plm_ctrl_t c;
        c = '{f[3], f[2], f[1], f[0], mf, rf};
        return {22'h0, c};
    endfunction
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge pclk) if (psel && penable && pready && want && exq.size() > 0) begin
        e = exq.pop_front();
        check("apb read", {pslverr, prdata} & e.m, e.v);
    end
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (90000) @(posedge pclk);
        check("run length", 1'b0, 1'b1);
        end_sim();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; want = 1'b0; run = 1'b1; fb_fast = 1'b0; strap = 3'h7;
        stop_pll_off = 1'b0; lfsr = 16'h68CB; err_total = 0; n_compared = 0;
        do_reset(3'h7);
        rd(ADDR_CTRL, 33'h3FF, {23'h0, CTRL_RESET});
        rd(ADDR_CAUSE, 33'h3, 33'h0);
        rd(ADDR_STAT, 33'h337, 33'h130);
        rd(12'h0FC, 33'h1_0000_0000, 33'h1_0000_0000);
        check("fb select", synth_cfg_o.fb_sel, FB_VCO_DIV);
        poll(STAT_LOCK_BIT, 1'b1);
        rd(ADDR_STAT, 33'h3, 33'h3);
        check("reset out", sys_reset_o, 1'b0);
        check("pfd in phase", {pfd_up, pfd_dn}, 2'b00);
        $display("test reset and first lock done");
        for (i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(ADDR_CTRL, ctl(3'h0, lfsr[2:0], 4'h0));
            rd(ADDR_STAT, 33'h3, 33'h3);
            check("rfd out", synth_cfg_o.output_reduce_divider, lfsr[2:0]);
        end
        for (i = 1; i < 8; i++) begin
            wr(ADDR_CTRL, ctl(i[2:0], 3'h1, 4'h0));
            rd(ADDR_STAT, 33'h303, (i < 2) ? 33'h100 : (i < 6) ? 33'h200 : 33'h300);
            check("pll source", synth_cfg_o.src_pll, 1'b1);
        end
        poll(STAT_LOCK_BIT, 1'b1);
        rd(ADDR_STAT, 33'h3, 33'h3);
        stop_pll_off <= 1'b1;
        fb_fast <= 1'b1;
        poll(STAT_LOCK_BIT, 1'b0);
        stop_pll_off <= 1'b0;
        fb_fast <= 1'b0;
        poll(STAT_LOCK_BIT, 1'b1);
        rd(ADDR_STAT, 33'h3, 33'h3);
        fb_fast <= 1'b1;
        poll(STAT_LOCK_BIT, 1'b0);
        rd(ADDR_STAT, 33'h3, 33'h0);
        fb_fast <= 1'b0;
        poll(STAT_LOCK_BIT, 1'b1);
        rd(ADDR_STAT, 33'h3, 33'h1);
        $display("test divider and lock loss done");
        wr(ADDR_CTRL, ctl(3'h7, 3'h1, 4'h1));
        fb_fast <= 1'b1;
        wait_rst(1'b1);
        fb_fast <= 1'b0;
        wait_rst(1'b0);
        rd(ADDR_CAUSE, 33'h3, 33'h1);
        rd(ADDR_CTRL, 33'h3FF, {23'h0, CTRL_RESET});
        wr(ADDR_CAUSE, 32'h3);
        poll(STAT_LOCK_BIT, 1'b1);
        wr(ADDR_CTRL, ctl(3'h0, 3'h1, 4'h6));
        run <= 1'b0;
        wait_rst(1'b1);
        run <= 1'b1;
        wait_rst(1'b0);
        rd(ADDR_CAUSE, 33'h3, 33'h2);
        rd(ADDR_STAT, 33'h4, 33'h0);
        wr(ADDR_CTRL, ctl(3'h0, 3'h1, 4'h2));
        run <= 1'b0;
        repeat (300) @(posedge pclk);
        run <= 1'b1;
        rd(ADDR_STAT, 33'h4, 33'h4);
        $display("test lock and clock loss resets done");
        do_reset(3'h4);
        rd(ADDR_STAT, 33'h330, 33'h010);
        check("one to one fb", synth_cfg_o.fb_sel, FB_SYSTEM_CLOCK_PIN);
        check("one to one mult", synth_cfg_o.mult, 4'h1);
        wr(ADDR_CTRL, 32'h0000_0201);
        repeat (2) @(posedge pclk);
        check("system_clock_pin off fb", synth_cfg_o.fb_sel, FB_VCO_HALF);
        do_reset(3'h6);
        rd(ADDR_STAT, 33'h30, 33'h20);
        do_reset(3'h0);
        wait_rst(1'b0);
        wr(ADDR_CTRL, ctl(3'h0, 3'h1, 4'h7));
        fb_fast <= 1'b1;
        run <= 1'b0;
        repeat (300) @(posedge pclk);
        run <= 1'b1;
        repeat (400) @(posedge pclk);
        rd(ADDR_STAT, 33'h37, 33'h0);
        check("ext reset out", sys_reset_o, 1'b0);
        $display("test clock modes done");
        end_sim();
    end
endmodule
